// *** dv/line_partner.sv ***
// Purpose: line-side model: slot ticks and cable completion of pause frames
// Assumes: one done pulse per requested pause frame
// Notes: slow mode stretches the frame time so busy can be read back
`timescale 1ns/1ps
module line_partner #(
  parameter int SLOT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic pause_frame_req,
  output logic tx_frame_done,
  output logic slot_tick
);
  int slot_cnt;
  int frame_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt <= 0;
      slot_tick <= 1'b0;
    end else begin
      slot_cnt <= (slot_cnt == SLOT - 1) ? 0 : slot_cnt + 1;
      slot_tick <= (slot_cnt == SLOT - 1);
    end
  end
  // counter runs on past the pulse, so a frame never gets two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt <= 0;
      tx_frame_done <= 1'b0;
    end else begin
      frame_cnt <= pause_frame_req ? frame_cnt + 1 : 0;
      tx_frame_done <= pause_frame_req && (frame_cnt == (slow ? 20 : 3));
    end
  end
endmodule

// *** dv/pause_fc_asserts.sv ***
// Purpose: port-level checks of the pause flow-control block
// Assumes: zero-wait apb answer
// Notes: bound from the bench top
`timescale 1ns/1ps
`include "pause_fc_consts.svh"
module pause_fc_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic phy_read_done,
  input wire logic [15:0] phy_read_word,
  input wire logic [15:0] phy_write_word,
  input wire logic tx_frame_done,
  input wire logic pause_frame_req,
  input wire logic [15:0] pause_frame_type,
  input wire logic [15:0] pause_frame_opcode,
  input wire logic rx_frame_end,
  input wire logic rx_pause_valid,
  input wire logic rx_filter_mode_pass,
  input wire logic rx_status_filter,
  input wire logic rx_status_valid,
  input wire logic rx_data_forward,
  input wire logic tx_hold
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  chk_apb_answer: assert property (s_setup |=> s_access)
    else $error("apb access not answered next cycle");
  chk_err_in_access: assert property (pslverr |-> psel && penable && pready)
    else $error("slave error outside access");
  chk_mgmt_word_load: assert property (phy_read_done |-> ##2 phy_write_word == $past(phy_read_word, 2))
    else $error("phy word not held");
  chk_ctrl_frame_fields: assert property (pause_frame_req |->
    pause_frame_type == `MAC_CTRL_TYPE && pause_frame_opcode == `PAUSE_OPCODE)
    else $error("control frame fields wrong");
  chk_busy_until_done: assert property (pause_frame_req && !tx_frame_done |=> pause_frame_req)
    else $error("pause frame dropped early");
  chk_busy_drops_after: assert property (pause_frame_req && tx_frame_done |=> !pause_frame_req)
    else $error("pause frame held after done");
  chk_hold_has_cause: assert property ($rose(tx_hold) |-> $past(rx_frame_end && rx_pause_valid, 2))
    else $error("hold without pause frame");
  chk_rx_forward: assert property (rx_frame_end |=> rx_status_valid && rx_data_forward)
    else $error("frame not forwarded");
  chk_filter_override: assert property (rx_frame_end && rx_filter_mode_pass |=> rx_status_filter)
    else $error("filter mode not honoured");
  chk_filter_plain: assert property (rx_frame_end && !rx_pause_valid && !rx_filter_mode_pass |=> !rx_status_filter)
    else $error("filter set on plain frame");
endmodule

// *** dv/testbench.sv ***
// Purpose: self-checking bench for the pause flow-control block
// Assumes: slot time shortened in the line model
// Notes: line reg bits: tx enable, full duplex, send pause, back pressure
`timescale 1ns/1ps
`include "pause_fc_consts.svh"
module testbench;
  localparam int SLOT = 4;
  logic pclk, presetn, psel, penable, pwrite, mb, rdd, rx_end, rx_pv, rx_pass, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, data_m;
  logic [15:0] rdw, ww, pf_q, pf_t, pf_o, rx_q, q;
  logic pready, pslverr, rerr, tx_done, tick, pf_req, bp_on, tx_hold, st_f, st_v, fwd;
  int err_count = 0;
  int num_checks = 0;
  int seed = 27624;
  // register model: what software should read back
  logic [31:0] m_data = '0;
  logic [31:0] m_flow = '0;
  mac_pause_flow_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .management_busy_flag(mb), .phy_read_done(rdd), .phy_read_word(rdw), .tx_frame_done(tx_done),
    .rx_frame_end(rx_end), .rx_pause_valid(rx_pv), .rx_pause_quanta(rx_q), .rx_filter_mode_pass(rx_pass),
    .slot_tick(tick), .phy_write_word(ww), .pause_frame_req(pf_req), .pause_frame_quanta(pf_q),
    .pause_frame_type(pf_t), .pause_frame_opcode(pf_o), .backpressure_on(bp_on), .tx_hold(tx_hold),
    .rx_status_filter(st_f), .rx_status_valid(st_v), .rx_data_forward(fwd));
  line_partner #(.SLOT(SLOT)) partner_u (.pclk(pclk), .presetn(presetn), .slow(slow),
    .pause_frame_req(pf_req), .tx_frame_done(tx_done), .slot_tick(tick));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == `ADDR_PAUSE_FLOW_CTRL) begin
      m_flow = d & 32'hffff_0006;
    end
    if (w && a == `ADDR_PHY_MGMT_DATA && mb !== 1'b1) begin
      m_data = d & 32'h0000_ffff;
    end
  endtask
  task automatic rx_frame(input logic pv, input logic ps);
    @(posedge pclk);
    rx_end <= 1'b1;
    rx_pv <= pv;
    rx_pass <= ps;
    rx_q <= 16'h0003;
    @(posedge pclk);
    rx_end <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    tally_and_finish;
  end
  initial begin
    {psel, penable, pwrite, mb, rdd, rx_end, rx_pv, rx_pass, slow} = '0;
    paddr = '0;
    pwdata = '0;
    rdw = '0;
    rx_q = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `ADDR_PHY_MGMT_DATA, 0);
    cmp(rdata, 0);
    apb(0, `ADDR_PAUSE_FLOW_CTRL, 0);
    cmp(rdata, 0);
    apb(1, 12'h030, 32'hffff_ffff);
    cmp(rerr, 1);
    cmp(rdata, 0);
    data_m = $random(seed);
    apb(1, `ADDR_PHY_MGMT_DATA, data_m);
    mb <= 1'b1;
    apb(1, `ADDR_PHY_MGMT_DATA, ~data_m);
    mb <= 1'b0;
    apb(0, `ADDR_PHY_MGMT_DATA, 0);
    cmp(rdata, data_m & 32'h0000_ffff);
    q = 16'($random(seed));
    rdw <= q;
    rdd <= 1'b1;
    m_data = {16'h0000, q};
    @(posedge pclk);
    rdd <= 1'b0;
    apb(0, `ADDR_PHY_MGMT_DATA, 0);
    cmp(rdata, {16'h0000, q});
    q = 16'($random(seed));
    apb(1, `ADDR_PAUSE_FLOW_CTRL, {q, 16'hfff8});
    apb(0, `ADDR_PAUSE_FLOW_CTRL, 0);
    cmp(rdata, {q, 16'h0000});
    apb(1, `ADDR_PAUSE_FLOW_CTRL, {q, 16'h0006});
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      apb(1, `ADDR_LINE_CTRL, 32'h0000_0007);
      for (int i = 0; i < 40 && pf_req !== 1'b1; i++) @(posedge pclk);
      cmp(pf_req, 1);
      cmp(pf_q, q);
      if (s == 1) begin
        apb(0, `ADDR_PAUSE_FLOW_CTRL, 0);
        cmp(rdata, {q, 16'h0007});
      end
      for (int i = 0; i < 40 && pf_req !== 1'b0; i++) @(posedge pclk);
      apb(0, `ADDR_PAUSE_FLOW_CTRL, 0);
      cmp(rdata, {q, 16'h0006});
    end
    apb(1, `ADDR_LINE_CTRL, 32'h0000_0006);
    repeat (6) @(posedge pclk);
    cmp(pf_req, 0);
    apb(1, `ADDR_LINE_CTRL, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    cmp(bp_on, 0);
    apb(1, `ADDR_LINE_CTRL, 32'h0000_0009);
    repeat (3) @(posedge pclk);
    cmp(bp_on, 1);
    apb(0, `ADDR_PAUSE_FLOW_CTRL, 0);
    cmp(rdata, {q, 16'h0007});
    apb(1, `ADDR_LINE_CTRL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    cmp(bp_on, 0);
    apb(1, `ADDR_LINE_CTRL, 32'h0000_0002);
    rx_frame(1, 0);
    cmp(st_f, 1);
    @(posedge pclk);
    #1;
    cmp(tx_hold, 1);
    repeat (2 * SLOT - 2) @(posedge pclk);
    #1;
    cmp(tx_hold, 1);
    repeat (SLOT + 6) @(posedge pclk);
    #1;
    cmp(tx_hold, 0);
    apb(1, `ADDR_PAUSE_FLOW_CTRL, {q, 16'h0004});
    rx_frame(1, 0);
    repeat (3) @(posedge pclk);
    #1;
    cmp(tx_hold, 0);
    apb(1, `ADDR_PAUSE_FLOW_CTRL, {q, 16'h0006});
    apb(1, `ADDR_LINE_CTRL, 32'h0000_0000);
    rx_frame(1, 0);
    repeat (3) @(posedge pclk);
    #1;
    cmp(tx_hold, 0);
    for (int k = 0; k < 8; k++) begin
      apb(1, `ADDR_PAUSE_FLOW_CTRL, {q, 13'h0000, k[0], 2'b10});
      rx_frame(k[1], k[2]);
      cmp(st_f, k[2] | (k[0] & k[1]));
      cmp({st_v, fwd}, 2'b11);
    end
    apb(0, `ADDR_PHY_MGMT_DATA, 0);
    cmp(rdata, m_data);
    apb(0, `ADDR_PAUSE_FLOW_CTRL, 0);
    cmp(rdata, m_flow);
    tally_and_finish;
  end
endmodule
bind mac_pause_flow_control pause_fc_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .phy_read_done(phy_read_done),
  .phy_read_word(phy_read_word), .phy_write_word(phy_write_word), .tx_frame_done(tx_frame_done),
  .pause_frame_req(pause_frame_req), .pause_frame_type(pause_frame_type),
  .pause_frame_opcode(pause_frame_opcode), .rx_frame_end(rx_frame_end), .rx_pause_valid(rx_pause_valid),
  .rx_filter_mode_pass(rx_filter_mode_pass), .rx_status_filter(rx_status_filter),
  .rx_status_valid(rx_status_valid), .rx_data_forward(rx_data_forward), .tx_hold(tx_hold));

// *** hdl/mac_pause_flow_control.sv ***
// Purpose: mac pause flow control with its apb registers
// Assumes: frame-side strobes are synchronous to pclk
// Notes: phy management data register is a plain holding register
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "pause_fc_consts.svh"

module mac_pause_flow_control
  import pause_fc_pkg::*;
#(
  parameter int QW = 16,
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic management_busy_flag,
  input wire logic phy_read_done,
  input wire logic [15:0] phy_read_word,
  input wire logic tx_frame_done,
  input wire logic rx_frame_end,
  input wire logic rx_pause_valid,
  input wire logic [QW-1:0] rx_pause_quanta,
  input wire logic rx_filter_mode_pass,
  input wire logic slot_tick,
  output logic [15:0] phy_write_word,
  output logic pause_frame_req,
  output logic [QW-1:0] pause_frame_quanta,
  output logic [15:0] pause_frame_type,
  output logic [15:0] pause_frame_opcode,
  output logic backpressure_on,
  output logic tx_hold,
  output logic rx_status_filter,
  output logic rx_status_valid,
  output logic rx_data_forward
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0] mgmt_data_q;
  logic [QW-1:0] pause_quanta_value_q;
  logic pass_pause_frames_q;
  logic pause_function_enable_q;
  logic pause_in_progress_q;
  logic tx_enable_q;
  logic full_duplex_q;
  logic send_pause_q;
  logic backpress_req_q;
  tx_state_t tx_state_q;
  tx_state_t tx_state_d;
  logic rx_paused;

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] b);
    hit = (a == b);
  endfunction

  logic apb_access;
  logic wr_data;
  logic wr_flow;
  logic wr_line;
  logic mapped;
  assign apb_access = psel && penable;
  assign wr_data = apb_access && pwrite && hit(paddr, `ADDR_PHY_MGMT_DATA);
  assign wr_flow = apb_access && pwrite && hit(paddr, `ADDR_PAUSE_FLOW_CTRL);
  assign wr_line = apb_access && pwrite && hit(paddr, `ADDR_LINE_CTRL);
  assign mapped = hit(paddr, `ADDR_PHY_MGMT_DATA) || hit(paddr, `ADDR_PAUSE_FLOW_CTRL)
                  || hit(paddr, `ADDR_LINE_CTRL);

  // ----------------------------------------------------------------
  // phy management data
  // ----------------------------------------------------------------
  // a completed phy read wins over a host write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_data_q <= `RESET_PHY_MGMT_DATA;
    end else if (phy_read_done) begin
      mgmt_data_q <= phy_read_word;
    end else if (wr_data && !management_busy_flag) begin
      mgmt_data_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_write_word <= `RESET_PHY_MGMT_DATA;
    end else begin
      phy_write_word <= mgmt_data_q;
    end
  end

  // ----------------------------------------------------------------
  // flow control register
  // ----------------------------------------------------------------
  // written bit zero is ignored; busy belongs to hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_quanta_value_q <= `RESET_PAUSE_QUANTA;
      pass_pause_frames_q <= 1'b0;
      pause_function_enable_q <= 1'b0;
    end else if (wr_flow) begin
      pause_quanta_value_q <= pwdata[`FLOW_QUANTA_MSB:`FLOW_QUANTA_LSB];
      pass_pause_frames_q <= pwdata[`FLOW_PASS_BIT];
      pause_function_enable_q <= pwdata[`FLOW_ENABLE_BIT];
    end
  end

  // line control: transmitter enable, duplex, and flow triggers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enable_q <= 1'b0;
      full_duplex_q <= 1'b0;
      backpress_req_q <= 1'b0;
    end else if (wr_line) begin
      tx_enable_q <= pwdata[`LINE_TX_EN_BIT];
      full_duplex_q <= pwdata[`LINE_FULL_DUPLEX_BIT];
      backpress_req_q <= pwdata[`LINE_BACKPRESSURE_BIT];
    end
  end

  // send request is a one-shot; it waits for the frame to start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_pause_q <= 1'b0;
    end else if (wr_line && pwdata[`LINE_SEND_PAUSE_BIT]) begin
      send_pause_q <= 1'b1;
    end else if (tx_state_q == TX_FRAME || !tx_enable_q) begin
      send_pause_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pause transmit / back pressure
  // ----------------------------------------------------------------
  logic fc_tx_ok;
  assign fc_tx_ok = tx_enable_q && pause_function_enable_q;

  always_comb begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      TX_IDLE: begin
        if (fc_tx_ok && full_duplex_q && send_pause_q) begin
          tx_state_d = TX_FRAME;
        end else if (fc_tx_ok && !full_duplex_q && backpress_req_q) begin
          tx_state_d = TX_BACKPRESS;
        end
      end
      TX_FRAME: begin
        if (tx_frame_done) begin
          tx_state_d = TX_IDLE;
        end
      end
      TX_BACKPRESS: begin
        if (!fc_tx_ok || full_duplex_q || !backpress_req_q) begin
          tx_state_d = TX_IDLE;
        end
      end
      default: begin
        tx_state_d = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= TX_IDLE;
    end else begin
      tx_state_q <= tx_state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_in_progress_q <= 1'b0;
    end else begin
      pause_in_progress_q <= (tx_state_d != TX_IDLE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_frame_req <= 1'b0;
      backpressure_on <= 1'b0;
      pause_frame_quanta <= '0;
      pause_frame_type <= 16'h0000;
      pause_frame_opcode <= 16'h0000;
    end else begin
      pause_frame_req <= (tx_state_d == TX_FRAME);
      backpressure_on <= (tx_state_d == TX_BACKPRESS);
      pause_frame_quanta <= pause_quanta_value_q;
      pause_frame_type <= `MAC_CTRL_TYPE;
      pause_frame_opcode <= `PAUSE_OPCODE;
    end
  end

  // ----------------------------------------------------------------
  // receive pause decode
  // ----------------------------------------------------------------
  logic pause_accept;
  assign pause_accept = rx_frame_end && rx_pause_valid && pause_function_enable_q
                        && full_duplex_q;

  pause_timer #(
    .QW(QW)
  ) u_pause_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(pause_accept),
    .quanta(rx_pause_quanta),
    .slot_tick(slot_tick),
    .paused(rx_paused)
  );

  // clearing enable masks tx_hold; a hold-off already running keeps counting in the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold <= 1'b0;
    end else begin
      tx_hold <= rx_paused && pause_function_enable_q;
    end
  end

  // ----------------------------------------------------------------
  // receive status
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_status_filter <= 1'b0;
      rx_status_valid <= 1'b0;
      rx_data_forward <= 1'b0;
    end else begin
      rx_status_valid <= rx_frame_end;
      rx_data_forward <= rx_frame_end;
      if (rx_frame_end) begin
        if (rx_filter_mode_pass) begin
          rx_status_filter <= 1'b1;
        end else if (rx_pause_valid) begin
          rx_status_filter <= pass_pause_frames_q;
        end else begin
          rx_status_filter <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (hit(paddr, `ADDR_PHY_MGMT_DATA)) begin
          prdata <= {16'h0000, mgmt_data_q};
        end else if (hit(paddr, `ADDR_PAUSE_FLOW_CTRL)) begin
          prdata <= {pause_quanta_value_q, 13'h0000, pass_pause_frames_q,
                     pause_function_enable_q, pause_in_progress_q};
        end else if (hit(paddr, `ADDR_LINE_CTRL)) begin
          prdata <= {28'h000_0000, backpress_req_q, send_pause_q, full_duplex_q, tx_enable_q};
        end
      end
    end
  end

endmodule

// *** hdl/pause_timer.sv ***
// Purpose: receive-side pause hold-off counter
// Assumes: one slot tick per slot time from the mac
// Notes: load restarts the count with the new quanta
`timescale 1ns/1ps
module pause_timer #(
  parameter int QW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [QW-1:0] quanta,
  input wire logic slot_tick,
  output logic paused
);
  logic [QW-1:0] count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= quanta;
    end else if (slot_tick && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      paused <= 1'b0;
    end else if (load) begin
      paused <= (quanta != '0);
    end else if (slot_tick && count_q <= {{(QW-1){1'b0}}, 1'b1}) begin
      paused <= 1'b0;
    end
  end
endmodule

// *** pkg/pause_fc_consts.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the pause flow-control block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: register index times four gives the byte address
`ifndef PAUSE_FC_CONSTS_SVH
`define PAUSE_FC_CONSTS_SVH

`define IDX_PHY_MGMT_DATA 4'h7
`define IDX_PAUSE_FLOW_CTRL 4'h8
`define IDX_LINE_CTRL 4'h9
`define ADDR_PHY_MGMT_DATA 12'h01C
`define ADDR_PAUSE_FLOW_CTRL 12'h020
`define ADDR_LINE_CTRL 12'h024

`define FLOW_QUANTA_MSB 31
`define FLOW_QUANTA_LSB 16
`define FLOW_PASS_BIT 2
`define FLOW_ENABLE_BIT 1
`define FLOW_BUSY_BIT 0
`define LINE_TX_EN_BIT 0
`define LINE_FULL_DUPLEX_BIT 1
`define LINE_SEND_PAUSE_BIT 2
`define LINE_BACKPRESSURE_BIT 3

`define RESET_PHY_MGMT_DATA 16'h0000
`define RESET_PAUSE_QUANTA 16'h0000
`define PAUSE_FRAME_BYTES 8'd64
`define SLOT_BIT_TIMES 16'd512
`define PAUSE_OPCODE 16'h0001
`define MAC_CTRL_TYPE 16'h8808

`endif

// *** pkg/pause_fc_pkg.sv ***
// Purpose: types shared by the pause flow-control block
// Assumes: nothing
// Notes: transmit state codes differ in one bit from idle to frame, but in two bits from idle to back pressure
package pause_fc_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FRAME = 2'b01,
    TX_BACKPRESS = 2'b11
  } tx_state_t;
endpackage
